/* verilog/poc_pkg.sv */
package poc_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] POC_ADR_SEG   = 8'h00; // Output segment control
    localparam logic [7:0] POC_ADR_GATE  = 8'h04; // Gate chop control
    localparam logic [7:0] POC_ADR_IOSEL = 8'h08; // IO shutdown source select
    localparam logic [7:0] POC_ADR_SWT   = 8'h0C; // Software trip
    localparam logic [7:0] POC_ADR_STAT  = 8'h10; // System status

    // Register widths
    localparam int POC_SEG_W   = 9;
    localparam int POC_GATE_W  = 10;
    localparam int POC_IO_W    = 12;
    localparam int POC_DIV_W   = 8;
    localparam int POC_CNT_W   = 10;

    // Segment control fields
    localparam int POC_SEG_XA  = 8; // Crossover phase A
    localparam int POC_SEG_XB  = 7; // Crossover phase B
    localparam int POC_SEG_XC  = 6; // Crossover phase C
    // Disable bits 5..0 map to pins AL, AH, BL, BH, CL, CH
    localparam int POC_PIN_AL  = 5;
    localparam int POC_PIN_AH  = 4;
    localparam int POC_PIN_BL  = 3;
    localparam int POC_PIN_BH  = 2;
    localparam int POC_PIN_CL  = 1;
    localparam int POC_PIN_CH  = 0;

    // Gate chop control fields
    localparam int POC_GATE_DIV_LSB = 0; // Chop divider, 8 bits
    localparam int POC_GATE_CHOP_HI = 8; // Chop high-side outputs
    localparam int POC_GATE_CHOP_LO = 9; // Chop low-side outputs

    // System status fields
    localparam int POC_STAT_TRIP = 0; // Trip input level
    localparam int POC_STAT_SD   = 1; // Shutdown in force
    localparam int POC_STAT_POL  = 2; // Polarity pin level

    // Side masks over the six pins
    localparam logic [5:0] POC_HI_MASK = 6'h15;
    localparam logic [5:0] POC_LO_MASK = 6'h2A;

    // Reset values
    localparam logic [8:0]  POC_SEG_RST   = 9'h000;
    localparam logic [9:0]  POC_GATE_RST  = 10'h000;
    localparam logic [11:0] POC_IOSEL_RST = 12'hFFF;

    // Chop carrier period is this many times (divider + 1) cycles
    localparam int POC_CHOP_MULT = 4;

endpackage : poc_pkg

/* verilog/poc_out_stage.sv */
`timescale 1ns/1ps

module poc_out_stage #(
    parameter int N = 6                    // Number of gate pins
) (
    input  wire logic         i_clk,       // Core clock
    input  wire logic         i_arst_n,    // Async reset, active low
    input  wire logic         i_shutdown,  // Async shutdown level
    input  wire logic         i_pol,       // 1 = active-high pins
    input  wire logic [N-1:0] i_on,        // Per-pin on demand
    output logic      [N-1:0] o_pin        // Pin levels
);
    import poc_pkg::*;

    // Stage state
    typedef struct packed {
        logic [N-1:0] on_r;                // Registered on demand
    } poc_stage_s;

    poc_stage_s s_r;                       // Current state
    poc_stage_s s_nxt;                     // Next state
    logic       clr_n;                     // Combined async clear

    // Shutdown clears the on flops without any clock edge; a glitch on
    // a trip source can therefore drop outputs for a moment, which is
    // the safe direction for a gate driver.
    assign clr_n = i_arst_n & ~i_shutdown;

    // Next value: follow the demand
    always_comb begin
        s_nxt      = s_r;
        s_nxt.on_r = i_on;
    end

    // State register
    always_ff @(posedge i_clk or negedge clr_n) begin
        if (!clr_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Active level follows the polarity pin
    assign o_pin = i_pol ? s_r.on_r : ~s_r.on_r;

endmodule : poc_out_stage

/* verilog/poc_output_ctrl.sv */
// Notes on behaviour
// - Crossover bits 8,7,6 for A,B,C; reset clear
// - Crossover swaps high and low signals
// - Bits 5..0 disable AL,AH,BL,BH,CL,CH; reset clear
// - Disabled output held OFF regardless of duty
// - Disable gating follows crossover, per physical pin
// - Segment latched at sync edge, midpoint if double
// - Gate bit 8 chops high, bit 9 low
// - Chop period four times divider plus one
// - Reset clears whole gate chop register
// - Polarity pin low gives active-low outputs
// - Status bit 2 shows polarity pin level
// - Trip low forces outputs OFF, suppresses sync
// - Status bit 0 shows trip input level
// - IO select bit enables that line's shutdown
// - IO select resets to 0x0FFF
// - Any software trip write sets bit, shuts down
// - Software trip read returns bit, then clears
// - Shutdown raises trip interrupt, stops timing
// - Restart needs period and duties rewritten, inputs high
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps

module poc_output_ctrl #(
    parameter int IO_LINES = 12            // General IO lines
) (
    input  wire logic                I_CORE_CLK,   // Core clock
    input  wire logic                I_ARST_N,     // Async reset
    // Wishbone slave
    input  wire logic                I_WB_CYC,     // Cycle
    input  wire logic                I_WB_STB,     // Strobe
    input  wire logic                I_WB_WE,      // Write enable
    input  wire logic [7:0]          I_WB_ADR,     // Byte address
    input  wire logic [3:0]          I_WB_SEL,     // Byte selects
    input  wire logic [31:0]         I_WB_DAT,     // Write data
    output logic                     O_WB_ACK,     // Acknowledge
    output logic      [31:0]         O_WB_DAT,     // Read data
    // Timing unit side
    input  wire logic                I_TU_A_HI,    // Phase A high demand
    input  wire logic                I_TU_A_LO,    // Phase A low demand
    input  wire logic                I_TU_B_HI,    // Phase B high demand
    input  wire logic                I_TU_B_LO,    // Phase B low demand
    input  wire logic                I_TU_C_HI,    // Phase C high demand
    input  wire logic                I_TU_C_LO,    // Phase C low demand
    input  wire logic                I_TU_SYNC,    // Raw period sync
    input  wire logic                I_TU_MID,     // Midpoint pulse
    input  wire logic                I_DBL_UPDATE, // Double update mode
    input  wire logic                I_PERIOD_WR,  // Period reg written
    input  wire logic                I_DUTY_A_WR,  // Duty A written
    input  wire logic                I_DUTY_B_WR,  // Duty B written
    input  wire logic                I_DUTY_C_WR,  // Duty C written
    // Pins
    input  wire logic                I_POLARITY_SELECT_PIN, // 1 = act hi
    input  wire logic                I_TRIP_INPUT,          // Low = trip
    input  wire logic [IO_LINES-1:0] I_GENERAL_IO_LINE,     // IO levels
    output logic                     O_PHASE_A_HIGH_OUT,    // Gate AH
    output logic                     O_PHASE_A_LOW_OUT,     // Gate AL
    output logic                     O_PHASE_B_HIGH_OUT,    // Gate BH
    output logic                     O_PHASE_B_LOW_OUT,     // Gate BL
    output logic                     O_PHASE_C_HIGH_OUT,    // Gate CH
    output logic                     O_PHASE_C_LOW_OUT,     // Gate CL
    output logic                     O_PERIOD_SYNC_PULSE,   // Gated sync
    output logic                     O_TRIP_IRQ,            // Trip event
    output logic                     O_TIMER_RUN            // Timing enable
);
    import poc_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [POC_SEG_W-1:0]  seg_r;      // Software segment control
        logic [POC_SEG_W-1:0]  seg_act_r;  // Latched segment control
        logic [POC_GATE_W-1:0] gate_r;     // Gate chop control
        logic [IO_LINES-1:0]   iosel_r;    // IO shutdown select
        logic                  swt_r;      // Software trip bit
        logic                  pol_r;      // Sampled polarity pin
        logic                  trip_r;     // Sampled trip pin
        logic                  sync_d_r;   // Sync delayed for edge
        logic [POC_CNT_W-1:0]  chop_cnt_r; // Half period counter
        logic                  chop_r;     // Chop carrier
        logic [3:0]            rearm_r;    // Period/duty writes seen
        logic                  run_r;      // Timing unit enable
        logic                  sd_d_r;     // Shutdown delayed
        logic                  irq_r;      // Trip event pulse
        logic                  psync_r;    // Gated sync out
        logic                  ack_r;      // Bus acknowledge
        logic [31:0]           dat_r;      // Bus read data
    } poc_state_s;

    poc_state_s s_r;                       // Current state
    poc_state_s s_nxt;                     // Next state
    logic       sd_now;                    // Asynchronous shutdown
    logic [5:0] tu_on;                     // Demands in pin order
    logic [5:0] routed;                    // After crossover
    logic [5:0] chopped;                   // After chop gating
    logic [5:0] on_dem;                    // After disable gating
    logic [5:0] pins;                      // Pin levels from stage
    logic       req;                       // Bus request pending
    logic       wr_ack;                    // Write taking effect
    logic       rd_ack;                    // Read completing
    logic       seg_latch;                 // Segment latch moment

    // Half carrier period in cycles: two times (divider plus one)
    function automatic logic [POC_CNT_W-1:0] half_period(
        input logic [POC_DIV_W-1:0] div
    );
        logic [POC_CNT_W-1:0] n;
        n = {2'b00, div} + 10'h001;
        half_period = n << 1;
    endfunction : half_period

    // Merge byte lanes of a write into an old register value
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0]  sel
    );
        lane_merge = old_v;
        if (sel[0]) begin
            lane_merge[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            lane_merge[15:8] = new_v[15:8];
        end
    endfunction : lane_merge

    // Word match on the register address
    function automatic logic adr_is(
        input logic [7:0] adr,
        input logic [7:0] reg_adr
    );
        adr_is = (adr[7:2] == reg_adr[7:2]);
    endfunction : adr_is

    // Any enabled source low, or software trip, shuts the outputs down;
    // kept combinational so no clock edge is needed to act.
    assign sd_now = ~I_TRIP_INPUT
                  | (|(s_r.iosel_r & ~I_GENERAL_IO_LINE))
                  | s_r.swt_r;

    // Timing unit demands arranged in pin order
    assign tu_on = {I_TU_A_LO, I_TU_A_HI, I_TU_B_LO,
                    I_TU_B_HI, I_TU_C_LO, I_TU_C_HI};

    // Bus strobes; writes and reads act at the acknowledged edge
    assign req    = I_WB_CYC & I_WB_STB;
    assign wr_ack = req & I_WB_WE & s_r.ack_r;
    assign rd_ack = req & ~I_WB_WE & s_r.ack_r;

    // Latch at sync rising edge, or midpoint in double update mode
    assign seg_latch = (I_TU_SYNC & ~s_r.sync_d_r)
                     | (I_TU_MID & I_DBL_UPDATE);

    // Output path: crossover, then chop, then per-pin disable
    always_comb begin
        routed = tu_on;
        // Swap each pair whose crossover bit is set
        if (s_r.seg_act_r[POC_SEG_XA]) begin
            routed[POC_PIN_AL] = tu_on[POC_PIN_AH];
            routed[POC_PIN_AH] = tu_on[POC_PIN_AL];
        end
        if (s_r.seg_act_r[POC_SEG_XB]) begin
            routed[POC_PIN_BL] = tu_on[POC_PIN_BH];
            routed[POC_PIN_BH] = tu_on[POC_PIN_BL];
        end
        if (s_r.seg_act_r[POC_SEG_XC]) begin
            routed[POC_PIN_CL] = tu_on[POC_PIN_CH];
            routed[POC_PIN_CH] = tu_on[POC_PIN_CL];
        end
        // Carrier gates only on intervals; off stays off
        chopped = routed;
        if (s_r.gate_r[POC_GATE_CHOP_HI]) begin
            chopped = chopped & (~POC_HI_MASK | {6{s_r.chop_r}});
        end
        if (s_r.gate_r[POC_GATE_CHOP_LO]) begin
            chopped = chopped & (~POC_LO_MASK | {6{s_r.chop_r}});
        end
        // Disable applies to physical pins, after crossover
        on_dem = chopped & ~s_r.seg_act_r[5:0];
    end

    // Next state
    always_comb begin
        s_nxt = s_r;
        // Pin sampling
        s_nxt.pol_r    = I_POLARITY_SELECT_PIN;
        s_nxt.trip_r   = I_TRIP_INPUT;
        s_nxt.sync_d_r = I_TU_SYNC;
        // Segment control reaches the pins only at a sync edge, or at a midpoint in double update mode
        if (seg_latch) begin
            s_nxt.seg_act_r = s_r.seg_r;
        end
        // Chop carrier; a divider change may give one odd half period
        if (s_r.chop_cnt_r >= half_period(s_r.gate_r[7:0]) - 10'h001) begin
            s_nxt.chop_cnt_r = '0;
            s_nxt.chop_r     = ~s_r.chop_r;
        end else begin
            s_nxt.chop_cnt_r = s_r.chop_cnt_r + 10'h001;
        end
        // Shutdown edge raises the trip event for one cycle
        s_nxt.sd_d_r = sd_now;
        s_nxt.irq_r  = sd_now & ~s_r.sd_d_r;
        // Restart bookkeeping: shutdown forgets earlier writes
        if (sd_now) begin
            s_nxt.rearm_r = 4'h0;
        end else begin
            s_nxt.rearm_r = s_r.rearm_r | {I_PERIOD_WR, I_DUTY_A_WR,
                                           I_DUTY_B_WR, I_DUTY_C_WR};
        end
        s_nxt.run_r   = ~sd_now & (&s_r.rearm_r);
        // Sync passes only while not shut down
        s_nxt.psync_r = I_TU_SYNC & ~sd_now;
        // Bus acknowledge: one wait cycle, then a single ack cycle
        s_nxt.ack_r = req & ~s_r.ack_r;
        // Read data captured as ack rises
        if (req & ~s_r.ack_r & ~I_WB_WE) begin
            s_nxt.dat_r = 32'h0000_0000;
            if (adr_is(I_WB_ADR, POC_ADR_SEG)) begin
                s_nxt.dat_r[POC_SEG_W-1:0] = s_r.seg_r;
            end else if (adr_is(I_WB_ADR, POC_ADR_GATE)) begin
                s_nxt.dat_r[POC_GATE_W-1:0] = s_r.gate_r;
            end else if (adr_is(I_WB_ADR, POC_ADR_IOSEL)) begin
                s_nxt.dat_r[IO_LINES-1:0] = s_r.iosel_r;
            end else if (adr_is(I_WB_ADR, POC_ADR_SWT)) begin
                s_nxt.dat_r[0] = s_r.swt_r;
            end else if (adr_is(I_WB_ADR, POC_ADR_STAT)) begin
                s_nxt.dat_r[POC_STAT_TRIP] = s_r.trip_r;
                s_nxt.dat_r[POC_STAT_SD]   = s_r.sd_d_r;
                s_nxt.dat_r[POC_STAT_POL]  = s_r.pol_r;
            end else begin
                s_nxt.dat_r = 32'h0000_0000;    // Unmapped reads zero
            end
        end else if (!req) begin
            s_nxt.dat_r = 32'h0000_0000;
        end
        // Read of software trip clears it after returning it
        if (rd_ack && adr_is(I_WB_ADR, POC_ADR_SWT)) begin
            s_nxt.swt_r = 1'b0;
        end
        // Register writes at the edge the master sees ack
        if (wr_ack) begin
            if (adr_is(I_WB_ADR, POC_ADR_SEG)) begin
                s_nxt.seg_r = POC_SEG_W'(lane_merge(
                    16'(s_r.seg_r), I_WB_DAT[15:0], I_WB_SEL[1:0]));
            end else if (adr_is(I_WB_ADR, POC_ADR_GATE)) begin
                s_nxt.gate_r = POC_GATE_W'(lane_merge(
                    16'(s_r.gate_r), I_WB_DAT[15:0], I_WB_SEL[1:0]));
            end else if (adr_is(I_WB_ADR, POC_ADR_IOSEL)) begin
                s_nxt.iosel_r = IO_LINES'(lane_merge(
                    16'(s_r.iosel_r), I_WB_DAT[15:0], I_WB_SEL[1:0]));
            end else if (adr_is(I_WB_ADR, POC_ADR_SWT)) begin
                s_nxt.swt_r = 1'b1;
            end else begin
                s_nxt.swt_r = s_r.swt_r;        // Status, unmapped: no-op
            end
        end
    end

    // State register; reset values fixed constants only
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s_r            <= '0;
            s_r.seg_r      <= POC_SEG_RST;
            s_r.seg_act_r  <= POC_SEG_RST;
            s_r.gate_r     <= POC_GATE_RST;
            s_r.iosel_r    <= IO_LINES'(POC_IOSEL_RST);
            s_r.pol_r      <= 1'b1;             // Pull-up default
            s_r.trip_r     <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Gate pins with asynchronous shutdown clear
    poc_out_stage #(
        .N          (6)
    ) u_stage (
        .i_clk      (I_CORE_CLK),
        .i_arst_n   (I_ARST_N),
        .i_shutdown (sd_now),
        .i_pol      (s_r.pol_r),
        .i_on       (on_dem),
        .o_pin      (pins)
    );

    // Output wiring
    assign O_PHASE_A_LOW_OUT   = pins[POC_PIN_AL];
    assign O_PHASE_A_HIGH_OUT  = pins[POC_PIN_AH];
    assign O_PHASE_B_LOW_OUT   = pins[POC_PIN_BL];
    assign O_PHASE_B_HIGH_OUT  = pins[POC_PIN_BH];
    assign O_PHASE_C_LOW_OUT   = pins[POC_PIN_CL];
    assign O_PHASE_C_HIGH_OUT  = pins[POC_PIN_CH];
    assign O_PERIOD_SYNC_PULSE = s_r.psync_r;
    assign O_TRIP_IRQ          = s_r.irq_r;
    assign O_TIMER_RUN         = s_r.run_r;
    assign O_WB_ACK            = s_r.ack_r;
    assign O_WB_DAT            = s_r.dat_r;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);

    // Shutdown forces every pin to its off level at once
    a_trip_all_off: assert property (
        sd_now |-> (pins == (s_r.pol_r ? 6'h00 : 6'h3F)))
        else $error("pins not off during shutdown");

    a_sync_suppressed: assert property (
        sd_now |=> !O_PERIOD_SYNC_PULSE)
        else $error("sync passed during shutdown");

    a_seg_latched: assert property (
        seg_latch |=> (s_r.seg_act_r == $past(s_r.seg_r)))
        else $error("segment not latched at sync");

    a_seg_held: assert property (
        !seg_latch |=> $stable(s_r.seg_act_r))
        else $error("segment changed outside sync");

    a_disable_off: assert property (
        s_r.seg_act_r[POC_PIN_AL] |=>
            (O_PHASE_A_LOW_OUT != s_r.pol_r))
        else $error("disabled pin not off");

    a_cross_route: assert property (
        (s_r.seg_act_r[POC_SEG_XA] && !s_r.seg_act_r[POC_PIN_AL]
         && !s_r.gate_r[POC_GATE_CHOP_LO] && !sd_now) |=>
        (sd_now || O_PHASE_A_LOW_OUT ==
            ($past(I_TU_A_HI) ~^ s_r.pol_r)))
        else $error("crossover route wrong");

    a_trip_irq_once: assert property (
        $rose(sd_now) |=> O_TRIP_IRQ ##1 !O_TRIP_IRQ)
        else $error("trip event not one pulse");

    a_timer_stops: assert property (
        sd_now |=> !O_TIMER_RUN)
        else $error("timing not stopped");

    a_run_needs_rearm: assert property (
        O_TIMER_RUN |-> $past(&s_r.rearm_r))
        else $error("ran without rewrites");

    a_swt_set: assert property (
        (wr_ack && adr_is(I_WB_ADR, POC_ADR_SWT)) |=> s_r.swt_r)
        else $error("software trip not set");

    a_swt_read_clr: assert property (
        (rd_ack && adr_is(I_WB_ADR, POC_ADR_SWT)) |=> !s_r.swt_r)
        else $error("software trip not cleared");

    a_stat_polarity: assert property (
        ($rose(O_WB_ACK) && !I_WB_WE && adr_is(I_WB_ADR, POC_ADR_STAT))
        |-> (O_WB_DAT[POC_STAT_POL] == $past(s_r.pol_r)))
        else $error("status polarity wrong");

    a_chop_toggle: assert property (
        (s_r.chop_cnt_r == half_period(s_r.gate_r[7:0]) - 10'h001)
        |=> (s_r.chop_r != $past(s_r.chop_r)))
        else $error("carrier missed toggle");

    c_trip_seen:   cover property ($rose(sd_now));
    c_crossover:   cover property (s_r.seg_act_r[POC_SEG_XB] && !sd_now);
    c_chop_active: cover property (s_r.gate_r[POC_GATE_CHOP_HI] && I_TU_A_HI);
    c_restart:     cover property ($rose(O_TIMER_RUN));

endmodule : poc_output_ctrl

/* tb/poc_fault_model.sv */
`timescale 1ns/1ps
// Fault sensors in front of the trip pin and the IO lines
module poc_fault_model (
    input  wire logic        i_trip,   // Overcurrent fault present
    input  wire logic [11:0] i_io_flt, // Per-line fault present
    output logic             o_trip_n, // Trip pin, low on fault
    output logic      [11:0] o_io      // IO lines, low on fault
);
    // Sensors answer at once; no filtering, so glitches pass too
    assign o_trip_n = ~i_trip;
    assign o_io     = ~i_io_flt;
endmodule : poc_fault_model

/* tb/test_pwm_output_control_shutdown.sv */
`timescale 1ns/1ps
module test_pwm_output_control_shutdown;
    import poc_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0;         // Clock, reset
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
    logic [7:0]  adr = 8'h00;                      // Byte address
    logic [31:0] dat = 32'h0;                      // Write data
    logic [5:0]  tu = 6'h00;                       // Demands, pin order
    logic [3:0]  wr4 = 4'h0;                       // Period, duty writes
    logic        syn = 1'b0, mid = 1'b0, dbl = 1'b0; // Latch inputs
    logic        pol = 1'b1, trq = 1'b0;           // Polarity, fault
    logic [11:0] iof = 12'hFFF;                    // IO faults
    logic        trip_n, ack, psync, irq, run;     // Pins and flags
    logic [11:0] io;                               // IO line levels
    logic [31:0] rdat;                             // Read data
    wire  [5:0]  pins;                             // AL,AH,BL,BH,CL,CH
    logic [1:0]  smp = 2'h0;                       // Sample kind
    logic [7:0]  irqs = 8'h00, ie = 8'h01;         // Irq seen, expected
    logic [7:0]  meas = 8'h00, lf = 8'h48;         // Period, random
    logic [8:0]  seg = 9'h000;                     // Segment in force
    logic [31:0] exp_q[$];                         // Notes, oldest first
    int          mismatches = 0, check_count = 0;
    // Free running core clock
    always #2 clk = ~clk;
    poc_output_ctrl #(.IO_LINES(12)) dut_u (
        .I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h3),
        .I_WB_DAT(dat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
        .I_TU_A_HI(tu[4]), .I_TU_A_LO(tu[5]), .I_TU_B_HI(tu[2]),
        .I_TU_B_LO(tu[3]), .I_TU_C_HI(tu[0]), .I_TU_C_LO(tu[1]),
        .I_TU_SYNC(syn), .I_TU_MID(mid), .I_DBL_UPDATE(dbl),
        .I_PERIOD_WR(wr4[0]), .I_DUTY_A_WR(wr4[1]),
        .I_DUTY_B_WR(wr4[2]), .I_DUTY_C_WR(wr4[3]),
        .I_POLARITY_SELECT_PIN(pol), .I_TRIP_INPUT(trip_n),
        .I_GENERAL_IO_LINE(io), .O_PHASE_A_HIGH_OUT(pins[4]),
        .O_PHASE_A_LOW_OUT(pins[5]), .O_PHASE_B_HIGH_OUT(pins[2]),
        .O_PHASE_B_LOW_OUT(pins[3]), .O_PHASE_C_HIGH_OUT(pins[0]),
        .O_PHASE_C_LOW_OUT(pins[1]), .O_PERIOD_SYNC_PULSE(psync),
        .O_TRIP_IRQ(irq), .O_TIMER_RUN(run));
    poc_fault_model flt_u (.i_trip(trq), .i_io_flt(iof),
        .o_trip_n(trip_n), .o_io(io));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // Expected pins: swap pairs, then gate per pin, then polarity
    function automatic logic [5:0] xp(input logic [5:0] d,
                                      input logic [8:0] s, input logic p);
        logic [5:0] r;
        r = d;
        if (s[8]) r[5:4] = {d[4], d[5]};
        if (s[7]) r[3:2] = {d[2], d[3]};
        if (s[6]) r[1:0] = {d[0], d[1]};
        r = r & ~s[5:0];
        return p ? r : ~r;
    endfunction : xp
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // Watcher: a read ack or a sample request retires the oldest note
    always @(posedge clk) begin
        if (irq === 1'b1) irqs = irqs + 8'h01;
        if ((ack === 1'b1 && we === 1'b0) || smp != 2'h0) begin
            if (exp_q.size() == 0) mismatches++;
            else check(smp == 2'h3 ? {31'h0, psync} : smp == 2'h2 ?
                {24'h0, meas} : smp == 2'h1 ?
                {16'h0, irqs, 1'b0, run, pins} : rdat, exp_q.pop_front());
        end
    end
    // Classic cycle held until ack, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) mismatches++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic see(input logic [1:0] k, input logic [31:0] e);
        exp_q.push_back(e);
        smp <= k;
        @(posedge clk);
        smp <= 2'h0;
        @(posedge clk);
    endtask : see
    // Pins, run and irq count; shut down means every pin off
    task automatic st(input logic r);
        see(2'h1, {16'h0, ie, 1'b0, r, xp(tu, r ? seg : 9'h03F, pol)});
    endtask : st
    // Period first, then the three duties, one pulse each
    task automatic restart();
        for (int i = 0; i < 4; i++) begin
            wr4 <= 4'h1 << i;
            @(posedge clk);
        end
        wr4 <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : restart
    task automatic latch(input logic m, input logic [8:0] s);
        wb(1'b1, POC_ADR_SEG, {23'h0, s});
        dbl <= m;
        if (m) mid <= 1'b1;
        else syn <= 1'b1;
        @(posedge clk);
        mid <= 1'b0;
        syn <= 1'b0;
        see(2'h3, {31'h0, ~m});
        @(posedge clk);
        seg = s;
    endtask : latch
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // Main sequence
    initial begin
        int n;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(POC_ADR_SEG, 32'h0);
        rd(POC_ADR_GATE, 32'h0);
        rd(POC_ADR_IOSEL, 32'hFFF);
        rd(POC_ADR_STAT, 32'h7);
        st(1'b0);
        iof <= 12'h000;
        restart();
        st(1'b1);
        // Segment change checked before its write and after its latch edge
        for (int i = 0; i < 6; i++) begin
            lf = lfsr(lf);
            tu <= lf[5:0];
            pol <= ~i[1];
            lf = lfsr(lf);
            repeat (3) @(posedge clk);
            st(1'b1);
            latch(i[0], {lf[2:0] | {3{i[0]}}, lf[7:2] & {6{i[1]}}});
            st(1'b1);
        end
        trq <= 1'b1;
        syn <= 1'b1;
        ie = ie + 8'h01;
        @(posedge clk);
        syn <= 1'b0;
        see(2'h3, 32'h0);
        st(1'b0);
        rd(POC_ADR_STAT, {29'h0, pol, 2'h2});
        rd(POC_ADR_SWT, 32'h0);
        trq <= 1'b0;
        restart();
        wb(1'b1, POC_ADR_SWT, 32'h0);
        ie = ie + 8'h01;
        st(1'b0);
        rd(POC_ADR_SWT, 32'h1);
        rd(POC_ADR_SWT, 32'h0);
        restart();
        wb(1'b1, POC_ADR_IOSEL, 32'h8);
        iof <= 12'h004;
        repeat (2) @(posedge clk);
        st(1'b1);
        iof <= 12'h008;
        ie = ie + 8'h01;
        repeat (2) @(posedge clk);
        st(1'b0);
        iof <= 12'h000;
        // Chop setup before restart; carrier period measured on AH
        wb(1'b1, POC_ADR_GATE, 32'h101);
        rd(POC_ADR_GATE, 32'h101);
        restart();
        tu <= POC_HI_MASK;
        latch(1'b0, 9'h000);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (pins[4] === k[0] && n < 99);
        end
        meas = n[7:0];
        see(2'h2, 32'h8);
        give_verdict();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule : test_pwm_output_control_shutdown
